// *** logic/mirror_trim_pkg.sv ***
/*
 * package for the output current mirror trim register bank:
 * register offsets, field positions, reset values and carrier structs.
 * assumes a simple synchronous register port from the spi slave logic.
 */
package mirror_trim_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] half_bridge_mirror_trim_addr = 8'h10;
    localparam logic [7:0] high_side_mirror_trim_addr = 8'h11;
    localparam logic [7:0] trim_reset_value = 8'h00;
    localparam logic [7:0] read_back_value = 8'h00;

    // ************************************************************
    // field positions (both registers share the 2/3/3 layout)
    // ************************************************************
    localparam int field2_hi = 7;
    localparam int field2_lo = 6;
    localparam int field3a_hi = 5;
    localparam int field3a_lo = 3;
    localparam int field3b_hi = 2;
    localparam int field3b_lo = 0;
    localparam logic [2:0] trim3_reserved_code = 3'h4;
    localparam logic [2:0] trim3_zero_code = 3'h0;
    localparam logic [1:0] trim2_zero_code = 2'h0;

    // register access request from the spi slave
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

    // trim codes presented to the mirrors, one 3-bit code per mirror
    typedef struct packed {
        logic [2:0] bridge12;
        logic [2:0] bridge34;
        logic [2:0] highside23;
        logic [2:0] highside1;
        logic       bridge12_wide;
        logic       bridge34_wide;
    } trim_out_type;

    // state of the register bank, all but the reserved-code flag
    typedef struct packed {
        logic [1:0]   bridge12_trim_sense0;
        logic [2:0]   bridge34_trim_sense1;
        logic [2:0]   bridge12_trim_sense1;
        logic [1:0]   bridge34_trim_sense0;
        logic [2:0]   highside23_trim;
        logic [2:0]   highside1_trim;
        logic [7:0]   rdata;
        logic         rvalid;
        trim_out_type trim;
    } trim_state_type;

    // state after reset: every trim field zero, reads zero
    localparam trim_state_type trim_state_reset = '0;

endpackage

// *** logic/output_current_mirror_trim_regs.sv ***
/*
 * write-only trim register bank for the load-current mirrors of the
 * four half-bridge and three high-side outputs.
 * assumes: the spi slave delivers one-cycle wr/rd strobes with address
 * and data synchronous to clk_i; current_sense_select_i is a level.
 */
//
// Function
// - The half-bridge trim register always reads as zero.
// - The high-side trim register always reads as zero.
// - Reset clears every field of the half-bridge trim register.
// - Reset clears every field of the high-side trim register.
// - Half-bridge bits 7:6 trim bridges 1-2 when sense select is 0.
// - Half-bridge bits 5:3 trim bridges 3-4 when sense select is 1.
// - Half-bridge bits 2:0 trim bridges 1-2 when sense select is 1.
// - High-side bits 7:6 trim bridges 3-4 when sense select is 0.
// - High-side bits 5:3 trim high-side outputs 2 and 3.
// - High-side bits 2:0 trim high-side output 1.
// - Bridges 1-2 use the two-bit field at select 0, three-bit at 1.
// - Bridges 3-4 use the high-side two-bit field at 0, else three-bit.
`timescale 1ns/10ps
`default_nettype none

module output_current_mirror_trim_regs
    import mirror_trim_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic current_sense_select_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output logic [2:0] bridge12_trim_o,
    output logic [2:0] bridge34_trim_o,
    output logic [2:0] highside23_trim_o,
    output logic [2:0] highside1_trim_o,
    output logic bridge12_wide_o,
    output logic bridge34_wide_o,
    output logic reserved_code_o
);

    // ************************************************************
    // state
    // ************************************************************
    trim_state_type state;
    trim_state_type next_state;
    reg_req_type req;
    logic rsv;
    logic next_rsv;
    logic hb_wr;
    logic hs_wr;

    // request bundle and per-register write decode
    assign req = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};
    assign hb_wr = req.wr && (req.addr == half_bridge_mirror_trim_addr);
    assign hs_wr = req.wr && (req.addr == high_side_mirror_trim_addr);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_state = state;
        // writes update only the addressed register
        if (hb_wr) begin
            next_state.bridge12_trim_sense0 =
                req.wdata[field2_hi:field2_lo];
            next_state.bridge34_trim_sense1 =
                req.wdata[field3a_hi:field3a_lo];
            next_state.bridge12_trim_sense1 =
                req.wdata[field3b_hi:field3b_lo];
        end
        if (hs_wr) begin
            next_state.bridge34_trim_sense0 =
                req.wdata[field2_hi:field2_lo];
            next_state.highside23_trim =
                req.wdata[field3a_hi:field3a_lo];
            next_state.highside1_trim =
                req.wdata[field3b_hi:field3b_lo];
        end
        // read data is always zero, write-only bank
        next_state.rvalid = req.rd;
        next_state.rdata = read_back_value;
        // mirror selection by current-sense select
        next_state.trim.bridge12_wide = current_sense_select_i;
        next_state.trim.bridge34_wide = current_sense_select_i;
        if (current_sense_select_i) begin
            next_state.trim.bridge12 =
                next_state.bridge12_trim_sense1;
            next_state.trim.bridge34 =
                next_state.bridge34_trim_sense1;
        end else begin
            next_state.trim.bridge12 =
                {1'b0, next_state.bridge12_trim_sense0};
            next_state.trim.bridge34 =
                {1'b0, next_state.bridge34_trim_sense0};
        end
        next_state.trim.highside23 = next_state.highside23_trim;
        next_state.trim.highside1 = next_state.highside1_trim;
    end

    // flag any applied three-bit code that is the reserved one
    always_comb begin
        next_rsv = (next_state.trim.highside23 == trim3_reserved_code) ||
                   (next_state.trim.highside1 == trim3_reserved_code) ||
                   (current_sense_select_i &&
                    ((next_state.trim.bridge12 == trim3_reserved_code) ||
                     (next_state.trim.bridge34 == trim3_reserved_code)));
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= trim_state_reset;
            rsv <= 1'b0;
        end else begin
            state <= next_state;
            rsv <= next_rsv;
        end
    end

    // outputs straight from flops
    assign rdata_o = state.rdata;
    assign rvalid_o = state.rvalid;
    assign bridge12_trim_o = state.trim.bridge12;
    assign bridge34_trim_o = state.trim.bridge34;
    assign highside23_trim_o = state.trim.highside23;
    assign highside1_trim_o = state.trim.highside1;
    assign bridge12_wide_o = state.trim.bridge12_wide;
    assign bridge34_wide_o = state.trim.bridge34_wide;
    assign reserved_code_o = rsv;

    // ************************************************************
    // sequences
    // ************************************************************
    // write to the half-bridge register
    sequence hb_write_s;
        wr_i && addr_i == half_bridge_mirror_trim_addr;
    endsequence

    // write to the high-side register
    sequence hs_write_s;
        wr_i && addr_i == high_side_mirror_trim_addr;
    endsequence

    // read of the half-bridge register
    sequence hb_read_s;
        rd_i && addr_i == half_bridge_mirror_trim_addr;
    endsequence

    // read of the high-side register
    sequence hs_read_s;
        rd_i && addr_i == high_side_mirror_trim_addr;
    endsequence

    // write to an address outside the bank
    sequence other_write_s;
        wr_i && addr_i != half_bridge_mirror_trim_addr &&
        addr_i != high_side_mirror_trim_addr;
    endsequence

    // quiet cycle: no write and a steady select
    sequence hold_s;
        !wr_i && $stable(current_sense_select_i);
    endsequence

    // ************************************************************
    // assertions
    // ************************************************************
    // read of half-bridge register answers zero
    AST_READ_ZERO: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        hb_read_s |=> rvalid_o && rdata_o == read_back_value)
        else $error("half-bridge trim read not zero");

    // read of high-side register answers zero
    AST_READ_ZERO_HS: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        hs_read_s |=> rvalid_o && rdata_o == read_back_value)
        else $error("high-side trim read not zero");

    // no read, no valid
    AST_RVALID_IDLE: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        !rd_i |=> !rvalid_o)
        else $error("read valid without a read");

    // read data stays zero between reads too
    AST_RDATA_IDLE: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        !rd_i |=> rdata_o == read_back_value)
        else $error("read data not zero");

    // reset clears the half-bridge fields
    AST_RESET_HB: assert property (
        @(posedge clk_i)
        !nrst_i |-> bridge12_trim_o == trim3_zero_code &&
            bridge34_trim_o == trim3_zero_code)
        else $error("bridge trim not cleared by reset");

    // reset clears the high-side fields
    AST_RESET_HS: assert property (
        @(posedge clk_i)
        !nrst_i |-> highside23_trim_o == trim3_zero_code &&
            highside1_trim_o == trim3_zero_code)
        else $error("high-side trim not cleared by reset");

    // reset clears the status flags as well
    AST_RESET_FLAG: assert property (
        @(posedge clk_i)
        !nrst_i |-> !reserved_code_o && !rvalid_o &&
            !bridge12_wide_o && !bridge34_wide_o)
        else $error("status not cleared by reset");

    // two-bit bridge 1-2 field at select 0
    AST_HB12_SENSE0: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (hb_write_s ##0 !current_sense_select_i)
        |=> bridge12_trim_o == {1'b0, $past(wdata_i[7:6])})
        else $error("bridge 1-2 two-bit trim not applied");

    // three-bit bridge 3-4 field at select 1
    AST_HB34_SENSE1: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (hb_write_s ##0 current_sense_select_i)
        |=> bridge34_trim_o == $past(wdata_i[5:3]))
        else $error("bridge 3-4 three-bit trim not applied");

    // three-bit bridge 1-2 field at select 1
    AST_HB12_SENSE1: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (hb_write_s ##0 current_sense_select_i)
        |=> bridge12_trim_o == $past(wdata_i[2:0]) && bridge12_wide_o)
        else $error("bridge 1-2 three-bit trim not applied");

    // two-bit bridge 3-4 field at select 0
    AST_HB34_SENSE0: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (hs_write_s ##0 !current_sense_select_i)
        |=> bridge34_trim_o == {1'b0, $past(wdata_i[7:6])} &&
            !bridge34_wide_o)
        else $error("bridge 3-4 two-bit trim not applied");

    // high-side 2-3 field
    AST_HS_FIELDS: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        hs_write_s |=> highside23_trim_o == $past(wdata_i[5:3]))
        else $error("high-side 2-3 trim not applied");

    // high-side 1 field
    AST_HS1_FIELD: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        hs_write_s |=> highside1_trim_o == $past(wdata_i[2:0]))
        else $error("high-side 1 trim not applied");

    // no trim output moves while nothing is written and the select is steady
    AST_HOLD: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        hold_s ##1 hold_s
        |=> $stable(highside1_trim_o) && $stable(bridge12_trim_o) &&
            $stable(highside23_trim_o) && $stable(bridge34_trim_o))
        else $error("trim changed without a write");

    // half-bridge write leaves high-side fields alone
    AST_HB_KEEPS_HS: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        hb_write_s
        |=> $stable(highside23_trim_o) && $stable(highside1_trim_o))
        else $error("high-side trim moved on half-bridge write");

    // high-side write leaves three-bit bridge codes alone
    AST_HS_KEEPS_HB: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (hs_write_s ##0 current_sense_select_i ##0
            $stable(current_sense_select_i))
        |=> $stable(bridge12_trim_o) && $stable(bridge34_trim_o))
        else $error("bridge trim moved on high-side write");

    // writes outside the bank change nothing
    AST_OTHER_ADDR: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (other_write_s ##0 $stable(current_sense_select_i))
        |=> $stable(bridge12_trim_o) && $stable(bridge34_trim_o) &&
            $stable(highside23_trim_o) && $stable(highside1_trim_o))
        else $error("trim moved on foreign write");

    // rising select picks the three-bit scale
    AST_SELECT: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        $rose(current_sense_select_i) |=> bridge12_wide_o && bridge34_wide_o)
        else $error("sense select not followed");

    // falling select picks the two-bit scale
    AST_SELECT_FALL: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        $fell(current_sense_select_i)
        |=> !bridge12_wide_o && !bridge34_wide_o)
        else $error("sense select fall not followed");

    // bridge 1-2 scale flag is set after a set select
    AST_WIDE12: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        current_sense_select_i |=> bridge12_wide_o)
        else $error("bridge 1-2 scale flag wrong");

    // bridge 3-4 scale flag is clear after a clear select
    AST_WIDE34: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        !current_sense_select_i |=> !bridge34_wide_o)
        else $error("bridge 3-4 scale flag wrong");

    // applied reserved bridge 3-4 code is flagged
    AST_RSV_HB34: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (hb_write_s ##0 current_sense_select_i ##0
            (wdata_i[5:3] == trim3_reserved_code))
        |=> reserved_code_o)
        else $error("reserved code not flagged");

endmodule

`default_nettype wire

// *** verif/testbench.sv ***
/*
 * self-checking bench for the mirror trim register bank.
 * assumes the loader model stands in for the controller at boot.
 */
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import mirror_trim_pkg::*;
    localparam logic [7:0] hb = 8'hb5;
    localparam logic [7:0] hs = 8'h6e;
    logic clk_i, nrst_i, sel, use_model, done;
    reg_req_type tb_req, mdl_req, req;
    logic [7:0] rdata;
    logic rvalid, w12, w34, resv;
    logic [2:0] b12, b34, h23, h1;
    int failures = 0;
    int checks = 0;
    int cycles = 0;

    assign req = use_model ? mdl_req : tb_req;

    trim_loader_model #(.half_bridge_byte(hb), .high_side_byte(hs)) u_mdl (
        .clk_i(clk_i), .nrst_i(nrst_i), .req_o(mdl_req), .done_o(done));

    output_current_mirror_trim_regs u_dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .wr_i(req.wr), .rd_i(req.rd),
        .addr_i(req.addr), .wdata_i(req.wdata),
        .current_sense_select_i(sel), .rdata_o(rdata), .rvalid_o(rvalid),
        .bridge12_trim_o(b12), .bridge34_trim_o(b34),
        .highside23_trim_o(h23), .highside1_trim_o(h1),
        .bridge12_wide_o(w12), .bridge34_wide_o(w34),
        .reserved_code_o(resv));

    // ************************************************************
    // clock, timeout and shared tasks
    // ************************************************************
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles >= 2000) begin
            failures++;
            results();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic outs(input logic [11:0] e, input logic [2:0] f);
        chk({5'h0, b12}, {5'h0, e[11:9]});
        chk({5'h0, b34}, {5'h0, e[8:6]});
        chk({2'h0, h23, h1}, {2'h0, e[5:0]});
        chk({5'h0, w12, w34, resv}, {5'h0, f});
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        tb_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_i);
        tb_req.wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        tb_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'hff};
        @(posedge clk_i);
        tb_req.rd <= 1'b0;
        #1;
        chk({7'h0, rvalid}, 8'h01);
        chk(rdata, read_back_value);
        @(posedge clk_i);
        #1;
        chk({7'h0, rvalid}, 8'h00);
    endtask

    task automatic boot();
        for (int i = 0; i < 20 && !done; i++) @(posedge clk_i);
        @(posedge clk_i);
        #1;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_boot();
        outs({1'b0, hb[7:6], 1'b0, hs[7:6], hs[5:0]}, 3'h0);
        @(posedge clk_i);
        sel <= 1'b1;
        @(posedge clk_i);
        #1;
        outs({hb[2:0], hb[5:3], hs[5:0]}, 3'h6);
    endtask

    task automatic t_writes();
        @(posedge clk_i);
        use_model <= 1'b0;
        rd(half_bridge_mirror_trim_addr);
        rd(high_side_mirror_trim_addr);
        rd(8'h12);
        wr(8'h12, 8'hff);
        outs({hb[2:0], hb[5:3], hs[5:0]}, 3'h6);
        wr(high_side_mirror_trim_addr, 8'h2f);
        outs({hb[2:0], hb[5:3], 6'h2f}, 3'h6);
        wr(half_bridge_mirror_trim_addr, 8'h20);
        outs({3'h0, 3'h4, 6'h2f}, 3'h7);
    endtask

    task automatic t_rerun();
        @(posedge clk_i);
        nrst_i <= 1'b0;
        use_model <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        outs(12'h000, 3'h0);
        @(posedge clk_i);
        nrst_i <= 1'b1;
        boot();
        outs({hb[2:0], hb[5:3], hs[5:0]}, 3'h6);
    endtask

    task automatic results();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        nrst_i = 1'b0;
        sel = 1'b0;
        use_model = 1'b1;
        tb_req = '0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        boot();
        t_boot();
        t_writes();
        t_rerun();
        results();
    end
endmodule
`default_nettype wire

// *** verif/trim_loader_model.sv ***
/*
 * controller model: copies two factory trim bytes into the bank.
 * assumes the bank takes one-cycle write strobes on clk_i.
 */
`timescale 1ns/10ps
`default_nettype none

module trim_loader_model
    import mirror_trim_pkg::*;
#(
    parameter logic [7:0] half_bridge_byte = 8'hb5,
    parameter logic [7:0] high_side_byte = 8'h6e
)
(
    input wire logic clk_i,
    input wire logic nrst_i,
    output reg_req_type req_o,
    output logic done_o
);
    logic [1:0] step;

    // ************************************************************
    // copy sequence, restarted by every reset
    // ************************************************************
    // step counter; factory bytes avoid the reserved code
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            step <= 2'h0;
        end else if (step != 2'h3) begin
            step <= step + 2'h1;
        end
    end

    // one write per register, back to back
    always_comb begin
        req_o = '0;
        req_o.wr = (step < 2'h2);
        req_o.addr = step[0] ? high_side_mirror_trim_addr :
                     half_bridge_mirror_trim_addr;
        req_o.wdata = step[0] ? high_side_byte : half_bridge_byte;
        done_o = step[1];
    end
endmodule
`default_nettype wire
